// [hdl/rsip_top.sv]
// Reset strap capture, interrupt pin handling and AXI4-Lite register file
`timescale 1ns/10ps
`default_nettype none
module rsip_top
   import rsip_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt pins
   input wire logic ext_irq_in_4,
   input wire logic ext_irq_in_5,
   input wire logic ext_irq_in_6,
   input wire logic ext_irq_in_7,
   input wire logic nmi_in,
   // Core side, same clock
   input wire logic svc_req,
   input wire logic [NUM_W-1:0] svc_num,
   input wire logic [1:0] pd_mode,
   output logic [N_EXT-1:0] ext_irq_event,
   output logic nmi_event,
   // Acknowledge and status pins
   output logic irq_ack_out,
   output logic [NUM_W-1:0] irq_number_out,
   output logic powerdown_status_out,
   output logic irq_out,
   // Expansion bus pins and clocks
   input wire logic [DATA_W-1:0] expansion_data_pins,
   input wire logic host_sync_clock_in,
   output logic fifo_clock_out,
   // Captured configuration
   output logic straps_valid,
   output logic [ST_MEM_HI-ST_MEM_LO:0] io_space_mem_type,
   output logic host_burst_last_pol,
   output logic host_write_read_pol,
   output logic host_sync_mode,
   output logic ext_arbitration,
   output logic fifo_mode_en,
   output logic big_endian,
   output logic reserved_select_strap,
   output logic [ST_BOOT_HI-ST_BOOT_LO:0] boot_mode
);
   // =====================================================================
   // Shared decode
   // Byte-lane merge of a write into an old word
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0] strb);
      logic [DATA_W-1:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction
   // =====================================================================
   // State
   logic [N_EXT-1:0] pol;          // Edge polarity field
   logic [EV_W-1:0] status;        // Sticky events
   logic [EV_W-1:0] enable;        // Interrupt enables
   logic [DATA_W-1:0] strap;       // Captured straps
   logic [DATA_W-1:0] pin_s1;      // Strap pins, first stage
   logic [DATA_W-1:0] pin_s2;      // Strap pins, second stage
   logic [1:0] strap_cnt;          // Cycles since reset release
   logic hclk_s1;                  // Host clock, first stage
   logic hclk_s2;                  // Host clock, second stage
   logic [3:0] fifo_cnt;           // FIFO clock divider
   logic [NUM_W-1:0] last_num;     // Last serviced number
   logic aw_held;                  // Write address latched
   logic w_held;                   // Write data latched
   logic [ADDR_W-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic [3:0] w_strb;
   logic [N_EDGE-1:0] edge_pulse;  // Detector outputs
   // =====================================================================
   // Edge detectors
   wire [N_EDGE-1:0] edge_pin = {nmi_in, ext_irq_in_7, ext_irq_in_6, ext_irq_in_5,
                                 ext_irq_in_4};
   wire [N_EDGE-1:0] edge_pol = {POL_RISE, pol};
   genvar gi;
   generate
      for (gi = 0; gi < N_EDGE; gi++) begin : g_edge
         rsip_edge_if eif();
         assign eif.pin = edge_pin[gi];
         // per-input polarity; nonmaskable fixed to rising
         assign eif.pol = edge_pol[gi];
         assign edge_pulse[gi] = eif.pulse;
         rsip_edge_det u_det (
            .core_clk(core_clk),
            .rstn(rstn),
            .eif(eif)
         );
      end
   endgenerate
   // =====================================================================
   // Write channel decode
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_wr = aw_held & w_held & ~s_axi_bvalid;
   wire wr_ctrl = do_wr && (aw_addr == REG_CTRL);
   wire wr_clr = do_wr && (aw_addr == REG_CLR);
   wire wr_en = do_wr && (aw_addr == REG_EN);
   wire wr_ok;
   assign wr_ok = (aw_addr == REG_CTRL) || (aw_addr == REG_STAT) || (aw_addr == REG_CLR)
                  || (aw_addr == REG_EN) || (aw_addr == REG_STRAP) || (aw_addr == REG_HW);
   wire [DATA_W-1:0] ctrl_word = {{(DATA_W-N_EXT){1'b0}}, pol};
   wire [DATA_W-1:0] en_word = {{(DATA_W-EV_W){1'b0}}, enable};
   wire [DATA_W-1:0] ctrl_new = merge(ctrl_word, w_data, w_strb);
   wire [DATA_W-1:0] en_new = merge(en_word, w_data, w_strb);
   wire [DATA_W-1:0] clr_new = merge({DATA_W{1'b0}}, w_data, w_strb);
   wire [EV_W-1:0] clr_mask = wr_clr ? clr_new[EV_W-1:0] : {EV_W{1'b0}};
   wire next_aw_held = aw_held ? ~do_wr : aw_take;
   wire next_w_held = w_held ? ~do_wr : w_take;
   // Write channel flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= ~next_aw_held;
         s_axi_wready <= ~next_w_held;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end
   // Write response, held until taken
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // =====================================================================
   // Read channel
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [DATA_W-1:0] hw_word;
   assign hw_word = {{(DATA_W-HW_VALID-1){1'b0}}, straps_valid, last_num, pd_mode, hclk_s2};
   logic [DATA_W-1:0] rd_word;
   wire rd_ok;
   // Address decode as an if chain
   assign rd_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STAT)
                  || (s_axi_araddr == REG_CLR) || (s_axi_araddr == REG_EN)
                  || (s_axi_araddr == REG_STRAP) || (s_axi_araddr == REG_HW);
   always_comb begin
      if (s_axi_araddr == REG_CTRL) begin
         rd_word = ctrl_word;
      end else if (s_axi_araddr == REG_STAT) begin
         rd_word = {{(DATA_W-EV_W){1'b0}}, status};
      end else if (s_axi_araddr == REG_EN) begin
         rd_word = en_word;
      end else if (s_axi_araddr == REG_STRAP) begin
         rd_word = strap;
      end else if (s_axi_araddr == REG_HW) begin
         rd_word = hw_word;
      end else begin
         rd_word = '0;
      end
   end
   // Read data answers the cycle after the address is taken
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end
   // =====================================================================
   // Control, enable and sticky status
   wire [EV_W-1:0] events = {svc_req, edge_pulse};
   // Set wins over a clear in the same cycle
   wire [EV_W-1:0] next_status = (status & ~clr_mask) | events;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pol <= '0;
         enable <= '0;
         status <= '0;
         irq_out <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            pol <= ctrl_new[N_EXT-1:0];
         end
         if (wr_en) begin
            enable <= en_new[EV_W-1:0];
         end
         status <= next_status;
         irq_out <= |(next_status & (wr_en ? en_new[EV_W-1:0] : enable));
      end
   end
   // =====================================================================
   // Core-facing events and acknowledge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ext_irq_event <= '0;
         nmi_event <= 1'b0;
         irq_ack_out <= 1'b0;
         irq_number_out <= NUM_RESET;
         last_num <= NUM_RESET;
         powerdown_status_out <= 1'b0;
      end else begin
         ext_irq_event <= edge_pulse[N_EXT-1:0];
         nmi_event <= edge_pulse[EV_NMI];
         irq_ack_out <= svc_req;
         // number changes only with acknowledge; fetch order code
         if (svc_req) begin
            irq_number_out <= svc_num;
            last_num <= svc_num;
         end
         // high in power-down modes two and three
         powerdown_status_out <= (pd_mode == PD_MODE2) || (pd_mode == PD_MODE3);
      end
   end
   // =====================================================================
   // Strap capture
   // data pins synchronised, then sampled
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         hclk_s1 <= 1'b0;
         hclk_s2 <= 1'b0;
      end else begin
         pin_s1 <= expansion_data_pins;
         pin_s2 <= pin_s1;
         hclk_s1 <= host_sync_clock_in;
         hclk_s2 <= hclk_s1;
      end
   end
   wire strap_take = (strap_cnt == STRAP_WAIT) && !straps_valid;
   // one capture after release, held to next reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         strap_cnt <= '0;
         straps_valid <= 1'b0;
         strap <= STRAP_RST;
      end else begin
         if (strap_cnt != STRAP_WAIT) begin
            strap_cnt <= strap_cnt + 2'h1;
         end
         if (strap_take) begin
            straps_valid <= 1'b1;
            strap <= pin_s2;
         end
      end
   end
   // memory type of the four selects
   assign io_space_mem_type = strap[ST_MEM_HI:ST_MEM_LO];
   assign host_burst_last_pol = strap[ST_BLAST];
   assign host_write_read_pol = strap[ST_WR];
   assign host_sync_mode = strap[ST_SYNC];
   assign ext_arbitration = strap[ST_ARB];
   assign fifo_mode_en = strap[ST_FIFO];
   assign big_endian = strap[ST_ENDIAN];
   // boot mode; reserved strap reported, board keeps it low
   assign boot_mode = strap[ST_BOOT_HI:ST_BOOT_LO];
   assign reserved_select_strap = strap[ST_RSV];
   // =====================================================================
   // FIFO clock divider
   // FIFO clock made from the core clock
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fifo_cnt <= '0;
         fifo_clock_out <= 1'b0;
      end else if (fifo_cnt == FIFO_HALF) begin
         fifo_cnt <= '0;
         fifo_clock_out <= ~fifo_clock_out;
      end else begin
         fifo_cnt <= fifo_cnt + 4'h1;
      end
   end
   // =====================================================================
   // Checks
   // acknowledge follows every service request for one cycle
   a_ack_follows: assert property (@(posedge core_clk) disable iff (!rstn)
      svc_req |=> irq_ack_out)
      else $error("Service without acknowledge");
   // number is stable while acknowledge is absent
   a_num_stable: assert property (@(posedge core_clk) disable iff (!rstn)
      !irq_ack_out |-> $stable(irq_number_out))
      else $error("Number changed without acknowledge");
   a_num_code: assert property (@(posedge core_clk) disable iff (!rstn)
      irq_ack_out |-> irq_number_out == $past(svc_num))
      else $error("Number differs from serviced code");
   // power-down status tracks the mode one cycle later
   a_pd_status: assert property (@(posedge core_clk) disable iff (!rstn)
      ##1 powerdown_status_out == ($past(pd_mode) >= PD_MODE2))
      else $error("Power-down status wrong");
   a_strap_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      straps_valid |=> straps_valid && $stable(strap))
      else $error("Straps changed after capture");
   // capture comes three edges after release with pins taken
   a_strap_take: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(straps_valid) |-> strap == $past(pin_s2))
      else $error("Straps differ from sampled pins");
   // a detected edge on external input 0 sets its sticky flag
   a_edge_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
      edge_pulse[EV_EXT_LO] |=> status[EV_EXT_LO])
      else $error("External edge not recorded");
   // nonmaskable edge reaches its event output
   a_nmi_event: assert property (@(posedge core_clk) disable iff (!rstn)
      edge_pulse[EV_NMI] |=> nmi_event && status[EV_NMI])
      else $error("Nonmaskable edge lost");
   // FIFO clock holds for exactly its half period
   a_fifo_half: assert property (@(posedge core_clk) disable iff (!rstn)
      $changed(fifo_clock_out) |=> $stable(fifo_clock_out) [*1] ##1 $changed(fifo_clock_out))
      else $error("FIFO clock half period wrong");
   c_ack: cover property (@(posedge core_clk) disable iff (!rstn) irq_ack_out);
   c_irq: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irq_out));
   c_strap: cover property (@(posedge core_clk) disable iff (!rstn) $rose(straps_valid));
endmodule
`default_nettype wire

// [include/rsip_pkg.sv]
// Constants, register map and field layout for the reset strap and interrupt pin block
// =====================================================================
// Function
// - External interrupts edge-triggered, per-input polarity bit
// - Acknowledge pulses for every serviced interrupt
// - Number outputs valid while acknowledge high
// - Number code follows service fetch order
// - Power-down output high in modes two, three
// - Sample expansion data pins during reset; taken three edges after reset release here
// - Data bits 30..16 give select memory types
// - Bits 13, 12 give burst-last, write/read polarity
// - Bit 11 selects asynchronous or synchronous host
// - Bit 10 arbitration, bit 9 FIFO mode
// - Bit 8 selects little or big endian
// - Bits 4..0 boot mode; bit 7 held low
// - Drive FIFO clock out, accept host clock
`default_nettype none
package rsip_pkg;
   // =====================================================================
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =====================================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;   // Edge polarity field
   localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;   // Sticky event flags, read only
   localparam logic [ADDR_W-1:0] REG_CLR = 8'h08;    // Write one to clear, write only
   localparam logic [ADDR_W-1:0] REG_EN = 8'h0C;     // Interrupt enables
   localparam logic [ADDR_W-1:0] REG_STRAP = 8'h10;  // Captured strap word
   localparam logic [ADDR_W-1:0] REG_HW = 8'h14;     // Live hardware state
   // =====================================================================
   // Event layout of status, clear and enable
   localparam int EV_W = 6;
   localparam int EV_EXT_LO = 0;  // Four external inputs, bits 3..0
   localparam int EV_NMI = 4;     // Nonmaskable edge
   localparam int EV_ACK = 5;     // Acknowledge issued
   localparam int N_EXT = 4;
   localparam int N_EDGE = 5;     // Four external plus nonmaskable
   // =====================================================================
   // Strap field positions on the expansion data word
   localparam int ST_MEM_HI = 30;
   localparam int ST_MEM_LO = 16;
   localparam int ST_BLAST = 13;
   localparam int ST_WR = 12;
   localparam int ST_SYNC = 11;
   localparam int ST_ARB = 10;
   localparam int ST_FIFO = 9;
   localparam int ST_ENDIAN = 8;
   localparam int ST_RSV = 7;
   localparam int ST_BOOT_HI = 4;
   localparam int ST_BOOT_LO = 0;
   localparam logic [DATA_W-1:0] STRAP_RST = 32'h0000_0000;
   // Cycles after reset release before the synchronised pins are taken
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   // =====================================================================
   // Hardware state register layout
   localparam int HW_HCLK = 0;     // Synchronised host clock level
   localparam int HW_PD_LO = 1;    // Power-down mode, bits 2..1
   localparam int HW_NUM_LO = 3;   // Last serviced number, bits 6..3
   localparam int HW_VALID = 7;    // Straps captured
   // =====================================================================
   // Interrupt numbers, in service fetch order
   localparam int NUM_W = 4;
   localparam logic [NUM_W-1:0] NUM_RESET = 4'h0;
   localparam logic [NUM_W-1:0] NUM_NMI = 4'h1;
   localparam logic [NUM_W-1:0] NUM_EXT4 = 4'h4;
   // Power-down modes that raise the status output
   localparam logic [1:0] PD_MODE2 = 2'h2;
   localparam logic [1:0] PD_MODE3 = 2'h3;
   // =====================================================================
   // FIFO clock: 200 MHz core divided down, output period in ns
   localparam int CLK_NS = 5;
   localparam int FIFO_CLK_NS = 20;
   localparam int FIFO_HALF_CYC = FIFO_CLK_NS / (2 * CLK_NS);
   localparam logic [3:0] FIFO_HALF = 4'(FIFO_HALF_CYC - 1);
   // Polarity value meaning rising edge
   localparam logic POL_RISE = 1'b0;
endpackage
`default_nettype wire

// [include/rsip_edge_if.sv]
// Carrier between the pin block top and each edge detector
`timescale 1ns/10ps
`default_nettype none
interface rsip_edge_if;
   logic pin;    // Raw pin level, unsynchronised
   logic pol;    // Edge choice, rising when low
   logic pulse;  // One-cycle edge event
   modport det (input pin, input pol, output pulse);
   modport top (output pin, output pol, input pulse);
endinterface
`default_nettype wire

// [hdl/rsip_edge_det.sv]
// Synchronised edge detector for one interrupt pin
`timescale 1ns/10ps
`default_nettype none
module rsip_edge_det
   import rsip_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   rsip_edge_if.det eif
);
   logic sync1;  // First stage, read only by second
   logic sync2;  // Second stage
   logic prev;   // Last settled level
   logic arm1;   // Set one edge after release
   logic arm2;   // Set two edges after release
   logic armed;  // Low until prev holds a real level
   logic pulse;  // Registered event
   // Selected edge from settled levels
   wire rise = sync2 & ~prev;
   wire fall = ~sync2 & prev;
   wire hit = armed & ((eif.pol == POL_RISE) ? rise : fall);
   assign eif.pulse = pulse;
   // Two-flop synchroniser, history and pulse
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
         arm1 <= 1'b0;
         arm2 <= 1'b0;
         armed <= 1'b0;
         pulse <= 1'b0;
      end else begin
         sync1 <= eif.pin;
         sync2 <= sync1;
         prev <= sync2;
         // Arm only once prev holds a synchronised pin level, so a pin held
         // high through reset makes no false edge
         arm1 <= 1'b1;
         arm2 <= arm1;
         armed <= arm2;
         pulse <= hit;
      end
   end
   // edge of selected polarity makes one pulse
   a_edge_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
      pulse |-> $past(armed) && (($past(eif.pol) == POL_RISE) ?
         ($past(sync2) && !$past(prev)) : (!$past(sync2) && $past(prev))))
      else $error("Edge pulse without matching edge");
   a_pulse_single: assert property (@(posedge core_clk) disable iff (!rstn)
      pulse |=> !pulse)
      else $error("Edge pulse longer than one cycle");
   c_edge_seen: cover property (@(posedge core_clk) disable iff (!rstn) pulse);
endmodule
`default_nettype wire

// [tb/rsip_board.sv]
// Board model: interrupt sources, strap drivers and host clock
`timescale 1ns/10ps
`default_nettype none
module rsip_board #(parameter logic [31:0] STRAP = 32'h5A5A_3B1D) (
   input wire logic core_clk,
   input wire logic rstn,
   output logic [31:0] xd,
   output logic [3:0] ext,
   output logic nmi,
   output logic hclk
);
   // Interrupt pins and host clock idle low at start, data pins at the straps
   initial begin
      xd = STRAP;
      ext = 4'h0;
      nmi = 1'b0;
      hclk = 1'b0;
   end
   // straps with unassigned and reserved bits low
   always @(negedge rstn) xd = STRAP;
   // Bus carries other traffic once capture is over
   always @(posedge rstn) begin
      #40;
      xd = ~STRAP;
   end
   // Free-running host clock, unrelated to the core
   always #7 hclk = ~hclk;
   // Pin levels change just after a core edge
   task automatic drive(input logic [3:0] e, input logic n);
      @(posedge core_clk);
      ext <= e;
      nmi <= n;
   endtask
endmodule
`default_nettype wire

// [tb/reset_strap_and_interrupt_pins_test.sv]
// Self-checking bench for the strap and interrupt pin block
`timescale 1ns/10ps
`default_nettype none
module reset_strap_and_interrupt_pins_test import rsip_pkg::*; ;
   localparam logic [31:0] S = 32'h5A5A_3B1D;
   logic core_clk = 1'b0, rstn = 1'b0, svc_req = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, xd;
   logic [3:0] wstrb = 4'hF, svc_num = 4'h0, num, ext;
   logic [1:0] bresp, rresp, pd_mode = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, ack, pdo, irq, fclk, sval, hclk, nmi;
   logic [14:0] mem;
   logic [6:0] flags;
   logic [4:0] boot;
   logic [3:0] evt, evt_seen = 4'h0;
   // Gather every external event pulse seen
   always @(posedge core_clk) evt_seen <= evt_seen | evt;
   int err_total = 0, checks_done = 0;
   always #2.5 core_clk = ~core_clk;
   rsip_board board (.core_clk(core_clk), .rstn(rstn), .xd(xd), .ext(ext), .nmi(nmi), .hclk(hclk));
   rsip_top dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_irq_in_4(ext[0]), .ext_irq_in_5(ext[1]), .ext_irq_in_6(ext[2]),
      .ext_irq_in_7(ext[3]), .nmi_in(nmi), .svc_req(svc_req), .svc_num(svc_num),
      .pd_mode(pd_mode), .ext_irq_event(evt), .nmi_event(), .irq_ack_out(ack),
      .irq_number_out(num), .powerdown_status_out(pdo), .irq_out(irq),
      .expansion_data_pins(xd), .host_sync_clock_in(hclk), .fifo_clock_out(fclk),
      .straps_valid(sval), .io_space_mem_type(mem), .host_burst_last_pol(flags[6]),
      .host_write_read_pol(flags[5]), .host_sync_mode(flags[4]), .ext_arbitration(flags[3]),
      .fifo_mode_en(flags[2]), .big_endian(flags[1]), .reserved_select_strap(flags[0]),
      .boot_mode(boot));
   // Compare and count
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // AXI4-Lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask
   // AXI4-Lite read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask
   // Captured straps decode and hold while the pins move
   task automatic t_strap;
      logic [31:0] d;
      chk("straps_valid", {31'h0, sval}, 32'h1);
      chk("fields", {5'h0, mem, flags, boot}, {5'h0, S[30:16], S[13:7], S[4:0]});
      rd(REG_STRAP, d, RESP_OKAY);
      chk("strap_word", d, S);
   endtask
   // Per-input edge polarity and nonmaskable rising edge
   task automatic t_edge;
      logic [31:0] d;
      wr(REG_CTRL, 32'h5, RESP_OKAY);
      wr(REG_EN, 32'h3F, RESP_OKAY);
      wr(REG_CLR, 32'h3F, RESP_OKAY);
      board.drive(4'hF, 1'b0);
      repeat (8) @(posedge core_clk);
      rd(REG_STAT, d, RESP_OKAY);
      chk("rise", d, 32'hA);
      chk("irq_out", {31'h0, irq}, 32'h1);
      board.drive(4'h0, 1'b1);
      repeat (8) @(posedge core_clk);
      rd(REG_STAT, d, RESP_OKAY);
      chk("fall_nmi", d, 32'h1F);
      chk("ext_event", {28'h0, evt_seen}, 32'hF);
      wr(REG_CLR, 32'h3F, RESP_OKAY);
      rd(REG_STAT, d, RESP_OKAY);
      chk("cleared", {d[31:1], irq}, 32'h0);
   endtask
   // Acknowledge pulse and number for every code
   task automatic t_ack;
      logic [31:0] d;
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         svc_req <= 1'b1;
         svc_num <= i[3:0];
         @(posedge core_clk);
         svc_req <= 1'b0;
         #1;
         chk("ack", {31'h0, ack}, 32'h1);
         chk("number", {28'h0, num}, {28'h0, i[3:0]});
         @(posedge core_clk);
         #1;
         chk("ack_low", {31'h0, ack}, 32'h0);
      end
      rd(REG_STAT, d, RESP_OKAY);
      chk("ack_flag", d, 32'h20);
   endtask
   // Power-down status for each mode
   task automatic t_pd;
      for (int m = 0; m < 4; m++) begin
         @(posedge core_clk);
         pd_mode <= m[1:0];
         repeat (2) @(posedge core_clk);
         #1;
         chk("pd", {31'h0, pdo}, {31'h0, m >= 2});
      end
   endtask
   // FIFO clock rate and unmapped addresses
   task automatic t_misc;
      logic [31:0] d;
      logic p;
      int c = 0;
      @(posedge core_clk);
      #1;
      p = fclk;
      repeat (16) begin
         @(posedge core_clk);
         #1;
         if (fclk !== p) c++;
         p = fclk;
      end
      chk("fifo_clk", c, 32'd8);
      rd(8'h18, d, RESP_SLVERR);
      wr(8'h1C, 32'h1, RESP_SLVERR);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Two resets, the second in mid-run
   initial begin
      for (int r = 0; r < 2; r++) begin
         repeat (4) @(posedge core_clk);
         rstn <= 1'b1;
         repeat (12) @(posedge core_clk);
         t_strap();
         t_edge();
         if (r == 0) rstn <= 1'b0;
      end
      t_ack();
      t_pd();
      t_misc();
      conclude();
   end
   // Watchdog
   initial begin
      #50000;
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
